// ---- lpwq_defines.vh ----
/*
 * Constants for the low-power wake qualifier: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LPWQ_DEFINES_VH
`define LPWQ_DEFINES_VH

`define LPWQ_ADR_QUAL_PERIOD    8'h00
`define LPWQ_ADR_QUAL_SELECT    8'h04
`define LPWQ_ADR_LPM_CTRL0      8'h08
`define LPWQ_ADR_WAKE_ENABLE    8'h0C
`define LPWQ_ADR_STATUS         8'h10
`define LPWQ_ADR_COMMAND        8'h14

`define LPWQ_CTRL0_MODE_LSB     0
`define LPWQ_CTRL0_MODE_MSB     1
`define LPWQ_CTRL0_QSTBY_LSB    2
`define LPWQ_CTRL0_QSTBY_MSB    7
`define LPWQ_CTRL0_DIV_LSB      8
`define LPWQ_CTRL0_DIV_MSB      9
`define LPWQ_CTRL0_FLASH_SLEEP  10

`define LPWQ_MODE_IDLE          2'h0
`define LPWQ_MODE_STANDBY       2'h1
`define LPWQ_MODE_HALT          2'h2

`define LPWQ_CTRL0_RESET        32'h0000_0000
`define LPWQ_QPRD_RESET         8'h00
`define LPWQ_QSEL_RESET         8'h00

`define LPWQ_MIN_OSC_WAIT       4
`define LPWQ_XCLK_LOW_DELAY     38
`define LPWQ_HOLD_DIV_LOW       16
`define LPWQ_HOLD_DIV_MID       32
`define LPWQ_HOLD_DIV_HIGH      64
`define LPWQ_IDLE_RESUME        20
`define LPWQ_IDLE_RESUME_SLP    1050
`define LPWQ_STBY_RESUME        100
`define LPWQ_STBY_RESUME_SLP    1125
`define LPWQ_PLL_LOCK_CYCLES    131072

`endif

// ---- lpwq_qualifier.v ----
/*
 * Low-power mode sequencer with input qualification for eight general-purpose
 * inputs and the wake sources, reached over a classic Wishbone slave.
 * Assumes the oscillator clock arrives as a plain pin sampled on sys_clk and
 * that the wake sources keep their own pulse-width obligations.
 */
// Design decisions made here: the placing of the registers and register access over Wishbone.
`include "lpwq_defines.vh"

module lpwq_qualifier #(
  parameter NUM_IN    = 8,
  parameter PLL_LOCK  = `LPWQ_PLL_LOCK_CYCLES
) (
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [31:0]       wb_dat_i,
  input  wire [3:0]        wb_sel_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire [NUM_IN-1:0] gp_in,
  input  wire [NUM_IN-1:0] irq_in,
  input  wire              watchdog_interrupt,
  input  wire              nonmaskable_int_input,
  input  wire              external_reset_pin_n,
  input  wire              oscillator_clock,
  output reg  [NUM_IN-1:0] gp_qual_out,
  output reg               cpu_run,
  output reg               system_clock_out_en,
  output reg               external_clock_out_en,
  output reg               periph_clk_en,
  output reg               pll_en,
  output reg               watchdog_clk_en,
  output reg               wake_irq_pending,
  output reg               low_power_active
);

  localparam ST_RUN   = 6'b000001;
  localparam ST_DRAIN = 6'b000010;
  localparam ST_SLEEP = 6'b000100;
  localparam ST_LOCK  = 6'b001000;
  localparam ST_WAKE  = 6'b010000;
  localparam ST_IDLE  = 6'b100000;

  // Divide select 00 and 01 share the shortest hold.
  function [15:0] hold_cycles;
    input [1:0] div;
    begin
      case (div)
        2'h2:    hold_cycles = 16'd`LPWQ_HOLD_DIV_MID;
        2'h3:    hold_cycles = 16'd`LPWQ_HOLD_DIV_HIGH;
        default: hold_cycles = 16'd`LPWQ_HOLD_DIV_LOW;
      endcase
    end
  endfunction

  // Release passes two flops so every register leaves reset on one clean edge.
  reg               rst_s1_q;
  reg               rst_s2_q;
  wire              rst_sync_n = rst_s2_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Asynchronous pins pass two flops before anything looks at them.
  reg [NUM_IN+3:0] pin_s1_q;
  reg [NUM_IN+3:0] pin_s2_q;
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_q <= {(NUM_IN+4){1'b0}};
      pin_s2_q <= {(NUM_IN+4){1'b0}};
    end else begin
      pin_s1_q <= {oscillator_clock, ~external_reset_pin_n, nonmaskable_int_input,
                   watchdog_interrupt, gp_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire [NUM_IN-1:0] gp_sync  = pin_s2_q[NUM_IN-1:0];
  wire              wd_sync  = pin_s2_q[NUM_IN];
  wire              nmi_sync = pin_s2_q[NUM_IN+1];
  wire              xrs_sync = pin_s2_q[NUM_IN+2];
  wire              osc_sync = pin_s2_q[NUM_IN+3];

  reg [7:0]        qual_period_field_q;
  reg [NUM_IN-1:0] qual_select_reg_q;
  reg [31:0]       low_power_ctrl_reg0_q;
  reg [NUM_IN-1:0] wake_enable_q;
  reg              idle_cmd_q;
  wire [1:0] lpm_mode   = low_power_ctrl_reg0_q[`LPWQ_CTRL0_MODE_MSB:`LPWQ_CTRL0_MODE_LSB];
  wire [5:0] standby_wake_qual_count =
    low_power_ctrl_reg0_q[`LPWQ_CTRL0_QSTBY_MSB:`LPWQ_CTRL0_QSTBY_LSB];
  wire [1:0] clock_divide_select =
    low_power_ctrl_reg0_q[`LPWQ_CTRL0_DIV_MSB:`LPWQ_CTRL0_DIV_LSB];
  wire       flash_sleep = low_power_ctrl_reg0_q[`LPWQ_CTRL0_FLASH_SLEEP];

  // One shared sampling strobe serves the whole group of eight inputs.
  reg  [8:0] samp_cnt_q;
  wire       samp_tick = (qual_period_field_q == 8'h00) ||
                         (samp_cnt_q >= {qual_period_field_q, 1'b0} - 9'h001);
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) samp_cnt_q <= 9'h000;
    else if (samp_tick) samp_cnt_q <= 9'h000;
    else samp_cnt_q <= samp_cnt_q + 9'h001;
  end

  // Six samples span five periods, three samples span two.
  reg [5:0] hist_q [0:NUM_IN-1];
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : qual
      wire [5:0] h   = {hist_q[g][4:0], gp_sync[g]};
      wire       six = qual_select_reg_q[g];
      wire all1 = six ? (&h) : (&h[2:0]);
      wire all0 = six ? ~(|h) : ~(|h[2:0]);
      always @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          hist_q[g]      <= 6'h00;
          gp_qual_out[g] <= 1'b0;
        end else if (samp_tick) begin
          hist_q[g] <= h;
          if (all1) gp_qual_out[g] <= 1'b1;
          else if (all0) gp_qual_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

  wire [NUM_IN-1:0] irq_hit = gp_qual_out & irq_in & wake_enable_q;
  wire wake_any = (|irq_hit) || wd_sync || nmi_sync || xrs_sync;

  // Oscillator edge count gates the early-wake guard and the lock wait.
  reg        osc_prev_q;
  wire       osc_rise = osc_sync & ~osc_prev_q;
  reg [17:0] osc_cnt_q;
  reg [15:0] sys_cnt_q;
  reg [5:0]  state_q;
  reg [10:0] resume_cnt_q;
  reg [NUM_IN-1:0] wake_src_q;
  wire [10:0] resume_lim = (lpm_mode == `LPWQ_MODE_IDLE) ?
      (flash_sleep ? 11'd`LPWQ_IDLE_RESUME_SLP : 11'd`LPWQ_IDLE_RESUME) :
      (flash_sleep ? 11'd`LPWQ_STBY_RESUME_SLP : 11'd`LPWQ_STBY_RESUME);
  wire stby_wake_ok = (standby_wake_qual_count == 6'h00) ? 1'b1 :
                      (osc_cnt_q >= {12'h000, standby_wake_qual_count});
  // A clear that meets the exit set loses, so no wake is dropped.
  wire pend_clr = wake_irq_pending && wb_cyc_i && wb_stb_i && wb_we_i &&
                  wb_adr_i == `LPWQ_ADR_STATUS && wb_sel_i[0] && wb_dat_i[0];

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q               <= ST_RUN;
      osc_prev_q            <= 1'b0;
      osc_cnt_q             <= 18'h00000;
      sys_cnt_q             <= 16'h0000;
      resume_cnt_q          <= 11'h000;
      wake_src_q            <= {NUM_IN{1'b0}};
      cpu_run               <= 1'b1;
      system_clock_out_en   <= 1'b1;
      external_clock_out_en <= 1'b1;
      periph_clk_en         <= 1'b1;
      pll_en                <= 1'b1;
      watchdog_clk_en       <= 1'b1;
      wake_irq_pending      <= 1'b0;
      low_power_active      <= 1'b0;
    end else begin
      osc_prev_q <= osc_sync;
      if (pend_clr) begin
        wake_irq_pending <= 1'b0;
      end
      case (state_q)
        ST_RUN: begin
          if (idle_cmd_q) begin
            state_q          <= (lpm_mode == `LPWQ_MODE_IDLE) ? ST_IDLE : ST_DRAIN;
            cpu_run          <= 1'b0;
            low_power_active <= 1'b1;
            sys_cnt_q        <= 16'h0000;
            osc_cnt_q        <= 18'h00000;
          end
        end
        ST_IDLE: begin
          if (osc_rise) osc_cnt_q <= osc_cnt_q + 18'h00001;
          if (wake_any) begin
            state_q      <= ST_WAKE;
            resume_cnt_q <= 11'h000;
            wake_src_q   <= irq_hit;
          end
        end
        ST_DRAIN: begin
          if (osc_rise) osc_cnt_q <= osc_cnt_q + 18'h00001;
          sys_cnt_q <= sys_cnt_q + 16'h0001;
          // The external clock stops no later than the system clock, which stops at the later of both points.
          if (sys_cnt_q == `LPWQ_XCLK_LOW_DELAY - 1) begin
            external_clock_out_en <= 1'b0;
          end
          if (sys_cnt_q >= hold_cycles(clock_divide_select) - 16'h0001 &&
              sys_cnt_q >= `LPWQ_XCLK_LOW_DELAY - 1) begin
            state_q             <= ST_SLEEP;
            system_clock_out_en <= 1'b0;
            periph_clk_en       <= 1'b0;
            pll_en              <= (lpm_mode != `LPWQ_MODE_HALT);
            watchdog_clk_en     <= (lpm_mode != `LPWQ_MODE_HALT);
            osc_cnt_q           <= 18'h00000;
          end
        end
        ST_SLEEP: begin
          // Early pulses inside the guard are the source's fault and are ignored.
          if (osc_rise && osc_cnt_q != 18'h3FFFF) osc_cnt_q <= osc_cnt_q + 18'h00001;
          if ((|gp_sync) || wake_any) begin
            if (osc_cnt_q >= `LPWQ_MIN_OSC_WAIT && stby_wake_ok) begin
              wake_src_q <= irq_hit;
              osc_cnt_q  <= 18'h00000;
              resume_cnt_q <= 11'h000;
              state_q    <= (lpm_mode == `LPWQ_MODE_HALT) ? ST_LOCK : ST_WAKE;
              pll_en     <= 1'b1;
            end
          end else if (lpm_mode != `LPWQ_MODE_HALT) begin
            osc_cnt_q <= osc_cnt_q;
          end
        end
        ST_LOCK: begin
          if (osc_rise) osc_cnt_q <= osc_cnt_q + 18'h00001;
          if (osc_cnt_q >= PLL_LOCK[17:0] - 18'h00001) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          system_clock_out_en   <= 1'b1;
          external_clock_out_en <= 1'b1;
          periph_clk_en         <= 1'b1;
          watchdog_clk_en       <= 1'b1;
          resume_cnt_q <= resume_cnt_q + 11'h001;
          // A pin wake is qualified only after sleep is left, so sources gather here.
          wake_src_q   <= wake_src_q | irq_hit;
          if (resume_cnt_q >= resume_lim - 11'h001) begin
            state_q          <= ST_RUN;
            cpu_run          <= 1'b1;
            low_power_active <= 1'b0;
            if (|wake_src_q) begin
              wake_irq_pending <= 1'b1;
            end
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Ack masks the request for one cycle, so a held request is taken once every two cycles.
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h0000_0000;
      qual_period_field_q   <= `LPWQ_QPRD_RESET;
      qual_select_reg_q     <= `LPWQ_QSEL_RESET;
      low_power_ctrl_reg0_q <= `LPWQ_CTRL0_RESET;
      wake_enable_q         <= {NUM_IN{1'b0}};
      idle_cmd_q            <= 1'b0;
    end else begin
      wb_ack_o   <= wb_req;
      idle_cmd_q <= 1'b0;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `LPWQ_ADR_QUAL_PERIOD: begin
            if (wb_sel_i[0]) begin
              qual_period_field_q <= wb_dat_i[7:0];
            end
          end
          `LPWQ_ADR_QUAL_SELECT: begin
            if (wb_sel_i[0]) begin
              qual_select_reg_q <= wb_dat_i[NUM_IN-1:0];
            end
          end
          `LPWQ_ADR_LPM_CTRL0: begin
            if (wb_sel_i[0]) begin
              low_power_ctrl_reg0_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              low_power_ctrl_reg0_q[15:8] <= wb_dat_i[15:8];
            end
          end
          `LPWQ_ADR_WAKE_ENABLE: begin
            if (wb_sel_i[0]) begin
              wake_enable_q <= wb_dat_i[NUM_IN-1:0];
            end
          end
          `LPWQ_ADR_COMMAND: begin
            if (wb_sel_i[0] && wb_dat_i[0] && state_q == ST_RUN) begin
              idle_cmd_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `LPWQ_ADR_QUAL_PERIOD: wb_dat_o <= {24'h000000, qual_period_field_q};
          `LPWQ_ADR_QUAL_SELECT: wb_dat_o <= {24'h000000, qual_select_reg_q};
          `LPWQ_ADR_LPM_CTRL0:   wb_dat_o <= {16'h0000, low_power_ctrl_reg0_q[15:0]};
          `LPWQ_ADR_WAKE_ENABLE: wb_dat_o <= {24'h000000, wake_enable_q};
          `LPWQ_ADR_STATUS:      wb_dat_o <= {16'h0000, gp_qual_out, 2'h0, state_q[5:0]} |
                                             {31'h0, wake_irq_pending};
          default:               wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- lpwq_properties.sv ----
/* Checker bound to lpwq_qualifier: bus handshake and low-power sequencing.
   Assumes it sees only the design's top ports, clocked by sys_clk. */
module lpwq_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        watchdog_interrupt,
  input wire logic        cpu_run,
  input wire logic        system_clock_out_en,
  input wire logic        external_clock_out_en,
  input wire logic        periph_clk_en,
  input wire logic        pll_en,
  input wire logic        watchdog_clk_en,
  input wire logic        low_power_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] lp_cnt_q;
  // Saturates so a long halt never wraps back into the clock windows.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) lp_cnt_q <= 8'h00;
    else if (!low_power_active) lp_cnt_q <= 8'h00;
    else if (lp_cnt_q != 8'hFF) lp_cnt_q <= lp_cnt_q + 8'h01;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_entry_stops_cpu: assert property ($rose(low_power_active) |-> !cpu_run)
    else $error("cpu still running in low power");
  a_xclk_low_window: assert property (
    $fell(external_clock_out_en) && low_power_active |-> lp_cnt_q >= 8'h1F
    && lp_cnt_q <= 8'h2D) else $error("external clock low outside window");
  a_sysclk_hold: assert property (
    $fell(system_clock_out_en) && low_power_active |-> lp_cnt_q >= 8'h0F)
    else $error("system clock stopped early");
  a_standby_keeps: assert property (
    low_power_active && $fell(periph_clk_en) && pll_en |-> watchdog_clk_en)
    else $error("watchdog clock stopped in standby");
  a_wake_resume: assert property (
    $rose(watchdog_interrupt) && low_power_active && pll_en && lp_cnt_q > 8'h04
    |-> ##[1:130] cpu_run) else $error("no resume after watchdog wake");
endmodule

// ---- lpwq_wake_src.sv ----
/* Wake-source model: free-running oscillator plus watchdog, nonmaskable and
   reset-pin wake lines. Assumes wake() is called after low-power entry. */
module lpwq_wake_src (
  input  wire logic sys_clk,
  output logic      oscillator_clock,
  output logic      watchdog_interrupt,
  output logic      nonmaskable_int_input,
  output logic      external_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // The oscillator runs free; only halt would stop it and the core never sees that.
  initial begin
    oscillator_clock = 1'b0;
    watchdog_interrupt = 1'b0;
    nonmaskable_int_input = 1'b0;
    external_reset_pin_n = 1'b1;
    forever #100 oscillator_clock = ~oscillator_clock;
  end
  task automatic drive(input int src, input logic on);
    case (src)
      0: watchdog_interrupt <= on;
      1: nonmaskable_int_input <= on;
      default: external_reset_pin_n <= ~on;
    endcase
  endtask
  task automatic wake(input int src, input int osc_n);
    repeat (5) @(posedge oscillator_clock);
    @(posedge sys_clk);
    drive(src, 1'b1);
    repeat (osc_n) @(posedge oscillator_clock);
    @(posedge sys_clk);
    drive(src, 1'b0);
  endtask
endmodule

// ---- test_low_power_wake_qualifier.sv ----
/* Self-checking bench for lpwq_qualifier: registers, input qualification,
   idle, standby and halt entry and wake. Assumes the model and checker. */
`include "lpwq_defines.vh"
module test_low_power_wake_qualifier;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 16;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i, gp_in, irq_in;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  wire logic [31:0] wb_dat_o;
  wire logic [7:0]  gp_qual_out;
  wire logic        wb_ack_o, watchdog_interrupt, nonmaskable_int_input, oscillator_clock;
  wire logic        external_reset_pin_n, cpu_run, system_clock_out_en, external_clock_out_en;
  wire logic        periph_clk_en, pll_en, watchdog_clk_en, wake_irq_pending, low_power_active;
  int          errors, total_checks;
  logic [31:0] exp_q[$];
  int          tbl[4][5] = '{'{0, 0, 2, 4, 8}, '{0, 1, 5, 7, 11}, '{2, 0, 8, 10, 16},
                             '{2, 1, 20, 22, 30}};
  lpwq_qualifier #(.NUM_IN(8), .PLL_LOCK(LOCK)) u_dut (.sys_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .gp_in,
    .irq_in, .watchdog_interrupt, .nonmaskable_int_input, .external_reset_pin_n,
    .oscillator_clock, .gp_qual_out, .cpu_run, .system_clock_out_en, .external_clock_out_en,
    .periph_clk_en, .pll_en, .watchdog_clk_en, .wake_irq_pending, .low_power_active);
  lpwq_wake_src u_src (.sys_clk, .oscillator_clock, .watchdog_interrupt,
    .nonmaskable_int_input, .external_reset_pin_n);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      chk(0, "bus timeout");
      stop_test();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) chk(0, "read without note");
      else chk(wb_dat_o === exp_q.pop_front(), "read data");
    end
  end
  function automatic logic pick(input int s);
    case (s)
      0: return cpu_run;
      1: return external_clock_out_en;
      2: return system_clock_out_en;
      3: return gp_qual_out[0];
      4: return gp_qual_out[1];
      default: return watchdog_interrupt | nonmaskable_int_input | ~external_reset_pin_n;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (pick(s) !== v) begin
      chk(0, "wait timeout");
      stop_test();
    end
  endtask
  initial begin
    int n, m, h;
    logic [31:0] r;
    {errors, total_checks} = 0;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {gp_in, irq_in, wb_sel_i} = {8'h00, 8'h00, 4'hF};
    r = $urandom(76254);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`LPWQ_ADR_QUAL_PERIOD, 32'h0000_0000);
    rd(`LPWQ_ADR_QUAL_SELECT, 32'h0000_0000);
    rd(`LPWQ_ADR_LPM_CTRL0, 32'h0000_0000);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    r = $urandom;
    wb(1'b1, `LPWQ_ADR_QUAL_PERIOD, {24'h00_0000, r[7:0]});
    rd(`LPWQ_ADR_QUAL_PERIOD, {24'h00_0000, r[7:0]});
    wb(1'b1, `LPWQ_ADR_LPM_CTRL0, 32'h0000_00FC);
    rd(`LPWQ_ADR_LPM_CTRL0, 32'h0000_00FC);
    wb(1'b1, `LPWQ_ADR_QUAL_SELECT, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `LPWQ_ADR_QUAL_PERIOD, 32'(tbl[i][0]));
      h = tbl[i][1];
      gp_in[h] <= 1'b1;
      repeat (tbl[i][2]) @(posedge sys_clk);
      gp_in[h] <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk(pick(3 + h) === 1'b0, "glitch passed");
      gp_in[h] <= 1'b1;
      wait_for(3 + h, 1'b1, tbl[i][4], n);
      chk(n >= tbl[i][3], "qualified too soon");
      gp_in[h] <= 1'b0;
      wait_for(3 + h, 1'b0, tbl[i][4], n);
    end
    wb(1'b1, `LPWQ_ADR_QUAL_PERIOD, 32'h0000_0000);
    gp_in[7:2] <= r[15:10];
    repeat (20) @(posedge sys_clk);
    chk(gp_qual_out[7:2] === r[15:10], "random inputs");
    gp_in[7:2] <= 6'h00;
    wb(1'b1, `LPWQ_ADR_WAKE_ENABLE, 32'h0000_0001);
    wb(1'b1, `LPWQ_ADR_LPM_CTRL0, {30'h0, `LPWQ_MODE_IDLE});
    for (int s = 0; s < 3; s++) begin
      wb(1'b1, `LPWQ_ADR_COMMAND, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk(cpu_run === 1'b0 && low_power_active === 1'b1, "idle entry");
      fork
        u_src.wake(s, 3);
        begin
          wait_for(5, 1'b1, 40, n);
          wait_for(0, 1'b1, 24, n);
        end
      join
    end
    for (int d = 0; d < 4; d++) begin
      irq_in <= {7'h00, d[0]};
      h = d < 2 ? `LPWQ_HOLD_DIV_LOW : (d == 2 ? `LPWQ_HOLD_DIV_MID : `LPWQ_HOLD_DIV_HIGH);
      wb(1'b1, `LPWQ_ADR_LPM_CTRL0, 32'h0000_0005 | 32'(d << 8));
      wb(1'b1, `LPWQ_ADR_COMMAND, 32'h0000_0001);
      wait_for(1, 1'b0, 60, n);
      chk(n >= 31 && n <= 45, "external clock low time");
      wait_for(2, 1'b0, 80, m);
      chk(n + m >= h, "system clock hold");
      chk(periph_clk_en === 1'b0 && pll_en === 1'b1 && watchdog_clk_en === 1'b1, "standby");
      repeat (25) @(posedge sys_clk);
      gp_in[0] <= 1'b1;
      wait_for(0, 1'b1, 130, n);
      @(posedge sys_clk);
      chk(wake_irq_pending === d[0], "pending after standby");
      gp_in[0] <= 1'b0;
      wb(1'b1, `LPWQ_ADR_STATUS, 32'h0000_0001);
    end
    wb(1'b1, `LPWQ_ADR_LPM_CTRL0, {30'h0, `LPWQ_MODE_HALT});
    wb(1'b1, `LPWQ_ADR_COMMAND, 32'h0000_0001);
    wait_for(2, 1'b0, 80, n);
    chk(periph_clk_en === 1'b0, "halt clocks");
    fork
      u_src.wake(2, 18);
      begin
        wait_for(5, 1'b1, 40, n);
        wait_for(0, 1'b1, 1000, n);
        chk(n >= LOCK * 5 - 5, "lock wait too short");
      end
    join
    chk(pll_en === 1'b1 && periph_clk_en === 1'b1, "clocks after halt");
    stop_test();
  end
endmodule
bind lpwq_qualifier lpwq_properties u_props (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .watchdog_interrupt, .cpu_run,
  .system_clock_out_en, .external_clock_out_en, .periph_clk_en, .pll_en, .watchdog_clk_en,
  .low_power_active);
